/* rtl/psm_clkdiv.sv */
// Slow-mode divider producing the CPU and peripheral clock enable.
`timescale 1ns/10ps
module psm_clkdiv
(
   // Clock and reset.
   input  wire logic i_clk_sys,
   input  wire logic i_reset,
   // Controller side.
   psm_div_if.div    div
);

   psm_pkg::psm_div_state_t q;
   psm_pkg::psm_div_state_t n;
   logic [3:0]              last;

   always_comb
   begin
      // Divide by 2, 4, 8 or 16: the tick shows in the cycle after the last count, with the count back at zero.
      last = 4'((5'h01 << (3'(div.sel) + 3'h1)) - 5'h01);
      n = q;
      if (!div.slow_en)
      begin
         n.cnt  = 4'h0;
         n.tick = 1'b1;
      end
      else if (q.cnt >= last)
      begin
         n.cnt  = 4'h0;
         n.tick = 1'b1;
      end
      else
      begin
         n.cnt  = q.cnt + 4'h1;
         n.tick = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
         q <= '{cnt: 4'h0, tick: 1'b1};
      else if (div.ce)
         q <= n;
   end

   assign div.tick = q.tick; // see RULE_02

endmodule : psm_clkdiv

/* rtl/psm_ctrl.sv */
// Power saving mode controller with its Avalon-MM register slave.
`timescale 1ns/10ps
`include "psm_defs.svh"

// Contract
// RULE_01: Reset starts Run mode on master clock.
// RULE_02: Slow select divides clock by 2 to 16.
// RULE_03: Wait during slow mode gives Slow Wait.
// RULE_04: Wait stops only the CPU.
// RULE_05: Wait entry forces mask bits to 10.
// RULE_06: Wait ends on interrupt or reset vector.
// RULE_07: Wake interrupt stacks flags, sets priority mask.
// RULE_08: Halt enters Halt or Active Halt by enable.
// RULE_09: Active Halt keeps only oscillator and counter.
// RULE_10: Active Halt interrupt wake has no delay.
// RULE_11: Active Halt reset wake inserts stabilisation delay.
// RULE_12: Halt entries force mask 10, pending wakes.
// RULE_13: Active Halt with enable avoids watchdog reset.
// RULE_14: Enable cleared early finishes delay in Halt.
// RULE_15: Halt switches oscillator and peripherals off.
// RULE_16: Halt wake restarts oscillator, waits 256/4096.
// RULE_17: Watchdog option turns halt into watchdog reset.
// RULE_18: Software ensures wake event before Halt.
// RULE_19: Opcode 0x8E decodes as halt.
module psm_ctrl
#(
   parameter logic [7:0] WAIT_OPCODE = 8'h8F,
   parameter int         STAB_SHORT  = `PSM_STAB_SHORT,
   parameter int         STAB_LONG   = `PSM_STAB_LONG
)
(
   // Clock, reset and clock enable.
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_ce,
   // Avalon-MM register slave.
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   // CPU instruction stream.
   input  wire logic        i_instr_valid,
   input  wire logic [7:0]  i_opcode,
   // Wake-up sources.
   input  wire logic        i_irq_pending,
   input  wire logic        i_ext_irq,
   input  wire logic        i_rtc_irq,
   input  wire logic        i_halt_wake_irq,
   input  wire logic        i_reset_event,
   // Watchdog.
   input  wire logic        i_wdg_enabled,
   output logic             o_wdg_reset,
   output logic             o_wdg_hold,
   // Clock gating.
   output logic             o_osc_on,
   output logic             o_rtc_clk_en,
   output logic             o_cpu_clk_en,
   output logic             o_periph_clk_en,
   // CPU mode control.
   output logic             o_mask_force,
   output logic      [1:0]  o_mask_bits,
   output logic             o_irq_service,
   output logic             o_reset_fetch,
   output logic             o_slow_wait
);

   // Counts must fit the 13-bit delay counter, and the wait opcode must
   // differ from the halt opcode.
   if (STAB_SHORT < 1 || STAB_SHORT > 8191)
   begin : g_bad_short
      $error("psm_ctrl: short stabilisation count out of range");
   end
   if (STAB_LONG < 1 || STAB_LONG > 8191)
   begin : g_bad_long
      $error("psm_ctrl: long stabilisation count out of range");
   end
   if (WAIT_OPCODE == `PSM_OPC_HALT)
   begin : g_bad_opcode
      $error("psm_ctrl: wait opcode equals the halt opcode");
   end

   localparam logic [12:0] DLY_S = 13'(STAB_SHORT);
   localparam logic [12:0] DLY_L = 13'(STAB_LONG);

   psm_pkg::psm_state_t q;
   psm_pkg::psm_state_t n;
   psm_div_if           dv ();
   logic                req;
   logic                wr_go;
   logic                oscillator_interrupt_enable;
   logic                oie_nxt;
   logic [12:0]         dly;
   logic [31:0]         stat;

   psm_clkdiv u_div
   (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .div       (dv.div)
   );

   assign dv.ce      = i_ce;
   assign dv.slow_en = q.ctrl[`PSM_CTRL_SLOW_SEL];               // see RULE_02
   assign dv.sel     = q.ctrl[`PSM_CTRL_DIV_HI:`PSM_CTRL_DIV_LO]; // see RULE_02

   assign req   = i_avs_read | i_avs_write;
   assign wr_go = i_avs_write & q.ack;
   assign oscillator_interrupt_enable   = q.ctrl[`PSM_CTRL_OSC_IE];
   assign dly   = q.opt[`PSM_OPT_LONG_DLY] ? DLY_L : DLY_S;

   // Status word: one-hot mode, slow wait, oscillator and wake cause.
   always_comb
   begin
      stat = 32'h0;
      stat[`PSM_STAT_STATE_HI:`PSM_STAT_STATE_LO] = q.mode;
      stat[`PSM_STAT_SLOW_WAIT] = o_slow_wait;
      stat[`PSM_STAT_OSC_ON]    = o_osc_on;
      stat[`PSM_STAT_WAKE_RST]  = q.wake_rst;
   end

   // A write reaches the oscillator interrupt enable at once, so the guard
   // window check this cycle sees the new enable.
   always_comb
   begin
      oie_nxt = oscillator_interrupt_enable;
      if (wr_go && i_avs_address == `PSM_ADDR_CTRL)
         oie_nxt = i_avs_writedata[`PSM_CTRL_OSC_IE];
   end

   always_comb
   begin
      n = q;
      n.mask_force  = 1'b0;
      n.irq_service = 1'b0;
      n.reset_fetch = 1'b0;
      n.wdg_reset   = 1'b0;

      // Bus slave: one wait cycle, read data registered on the first.
      n.ack = req & ~q.ack;
      if (req && !q.ack)
      begin
         n.rdata = 32'h0;
         unique case (i_avs_address)
            `PSM_ADDR_CTRL: n.rdata[3:0] = q.ctrl;
            `PSM_ADDR_OPT:  n.rdata[1:0] = q.opt;
            `PSM_ADDR_STAT: n.rdata      = stat;
            default:        n.rdata      = 32'h0;
         endcase
      end
      if (wr_go && i_avs_address == `PSM_ADDR_CTRL)
         n.ctrl = i_avs_writedata[3:0];
      if (wr_go && i_avs_address == `PSM_ADDR_OPT)
         n.opt = i_avs_writedata[1:0];

      unique case (q.mode)
         psm_pkg::PSM_RUN:
         begin
            if (i_reset_event)
               n.reset_fetch = 1'b1;
            else if (i_instr_valid && i_opcode == `PSM_OPC_HALT) // see RULE_19
            begin
               if (oscillator_interrupt_enable)
               begin
                  n.mode       = psm_pkg::PSM_AHALT; // see RULE_08
                  n.mask_force = 1'b1;               // see RULE_12
               end
               else if (i_wdg_enabled && q.opt[`PSM_OPT_WDG_HALT])
                  n.wdg_reset = 1'b1;                // see RULE_17
               else
               begin
                  n.mode       = psm_pkg::PSM_HALT;  // see RULE_08
                  n.mask_force = 1'b1;               // see RULE_12
               end
            end
            else if (i_instr_valid && i_opcode == WAIT_OPCODE)
            begin
               n.mode       = psm_pkg::PSM_WAIT;     // see RULE_04
               n.mask_force = 1'b1;                  // see RULE_05
            end
         end
         psm_pkg::PSM_WAIT:
         begin
            if (i_reset_event)
            begin
               n.mode        = psm_pkg::PSM_RUN;     // see RULE_06
               n.reset_fetch = 1'b1;
            end
            else if (i_irq_pending)
            begin
               n.mode        = psm_pkg::PSM_RUN;     // see RULE_06
               n.irq_service = 1'b1;                 // see RULE_07
            end
         end
         psm_pkg::PSM_AHALT:
         begin
            if (i_reset_event)
            begin
               n.mode     = psm_pkg::PSM_STAB;       // see RULE_11
               n.dly_cnt  = dly;
               n.wake_rst = 1'b1;
               n.wake_irq = 1'b0;
            end
            else if (i_rtc_irq)
            begin
               // Oscillator kept running: the CPU resumes at once, the
               // delay window still runs for the enable check.
               n.mode        = psm_pkg::PSM_GUARD;   // see RULE_10
               n.dly_cnt     = dly;
               n.wake_rst    = 1'b0;
               n.irq_service = 1'b1;                 // see RULE_07
            end
            else if (i_ext_irq || i_irq_pending)
            begin
               n.mode        = psm_pkg::PSM_RUN;     // see RULE_10
               n.wake_rst    = 1'b0;
               n.irq_service = 1'b1;                 // see RULE_12
            end
         end
         psm_pkg::PSM_HALT:
         begin
            if (i_reset_event || i_halt_wake_irq)
            begin
               n.mode     = psm_pkg::PSM_STAB;       // see RULE_16
               n.dly_cnt  = dly;
               n.wake_rst = i_reset_event;
               n.wake_irq = ~i_reset_event;
            end
         end
         psm_pkg::PSM_STAB:
         begin
            if (i_reset_event)
            begin
               n.wake_rst = 1'b1;
               n.wake_irq = 1'b0;
            end
            if (q.dly_cnt <= 13'h1)
            begin
               n.mode        = psm_pkg::PSM_RUN;     // see RULE_16
               n.dly_cnt     = 13'h0;
               n.reset_fetch = q.wake_rst | i_reset_event; // see RULE_11
               n.irq_service = q.wake_irq & ~i_reset_event;
               n.wake_irq    = 1'b0;
            end
            else
               n.dly_cnt = q.dly_cnt - 13'h1;
         end
         psm_pkg::PSM_GUARD:
         begin
            if (i_reset_event)
            begin
               n.mode        = psm_pkg::PSM_RUN;
               n.dly_cnt     = 13'h0;
               n.reset_fetch = 1'b1;
            end
            else if (!oie_nxt)
            begin
               n.mode     = psm_pkg::PSM_STAB;       // see RULE_14
               n.dly_cnt  = q.dly_cnt;
               n.wake_irq = 1'b0;
            end
            else if (q.dly_cnt <= 13'h1)
            begin
               n.mode    = psm_pkg::PSM_RUN;
               n.dly_cnt = 13'h0;
            end
            else
               n.dly_cnt = q.dly_cnt - 13'h1;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
      begin
         q.mode        <= psm_pkg::PSM_RUN; // see RULE_01
         q.dly_cnt     <= 13'h0;
         q.wake_rst    <= 1'b0;
         q.wake_irq    <= 1'b0;
         q.ctrl        <= `PSM_CTRL_RESET;
         q.opt         <= `PSM_OPT_RESET;
         q.ack         <= 1'b0;
         q.rdata       <= 32'h0;
         q.mask_force  <= 1'b0;
         q.irq_service <= 1'b0;
         q.reset_fetch <= 1'b0;
         q.wdg_reset   <= 1'b0;
      end
      else if (i_ce)
         q <= n;
   end

   assign o_avs_waitrequest = req & ~q.ack;
   assign o_avs_readdata    = q.rdata;

   assign o_mask_force  = q.mask_force;             // see RULE_05
   assign o_mask_bits   = `PSM_MASK_ALL_ENABLED;    // see RULE_12
   assign o_irq_service = q.irq_service;            // see RULE_07
   assign o_reset_fetch = q.reset_fetch;            // see RULE_06
   assign o_wdg_reset   = q.wdg_reset;              // see RULE_17

   // The oscillator only stops in Halt; it restarts for the delay.
   assign o_osc_on     = q.mode != psm_pkg::PSM_HALT;   // see RULE_15
   assign o_rtc_clk_en = o_osc_on & i_ce;               // see RULE_09
   assign o_wdg_hold   = q.mode == psm_pkg::PSM_AHALT;  // see RULE_13

   // The CPU runs in Run and in the guard window, peripherals in Wait as
   // well; all of them pause between divider ticks.
   always_comb
   begin
      o_cpu_clk_en    = 1'b0;
      o_periph_clk_en = 1'b0;
      if (i_ce && dv.tick)
      begin
         unique case (q.mode)
            psm_pkg::PSM_RUN,
            psm_pkg::PSM_GUARD:
            begin
               o_cpu_clk_en    = 1'b1; // see RULE_01
               o_periph_clk_en = 1'b1;
            end
            psm_pkg::PSM_WAIT:
            begin
               o_cpu_clk_en    = 1'b0; // see RULE_04
               o_periph_clk_en = 1'b1; // see RULE_03
            end
            psm_pkg::PSM_AHALT,
            psm_pkg::PSM_HALT,
            psm_pkg::PSM_STAB:
            begin
               o_cpu_clk_en    = 1'b0; // see RULE_09
               o_periph_clk_en = 1'b0; // see RULE_15
            end
         endcase
      end
   end

   assign o_slow_wait = q.mode == psm_pkg::PSM_WAIT
                      && q.ctrl[`PSM_CTRL_SLOW_SEL];      // see RULE_03

endmodule : psm_ctrl

/* rtl/psm_defs.svh */
// Offsets, field positions, reset values and timing counts of the power-mode block.
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

// Register byte offsets on the Avalon-MM slave.
`define PSM_ADDR_CTRL        4'h0
`define PSM_ADDR_OPT         4'h4
`define PSM_ADDR_STAT        4'h8

// Control register fields.
`define PSM_CTRL_SLOW_SEL    0
`define PSM_CTRL_DIV_LO      1
`define PSM_CTRL_DIV_HI      2
`define PSM_CTRL_OSC_IE      3
`define PSM_CTRL_RESET       4'h0

// Option register fields.
`define PSM_OPT_LONG_DLY     0
`define PSM_OPT_WDG_HALT     1
`define PSM_OPT_RESET        2'h0

// Status register fields.
`define PSM_STAT_STATE_LO    0
`define PSM_STAT_STATE_HI    5
`define PSM_STAT_SLOW_WAIT   6
`define PSM_STAT_OSC_ON      7
`define PSM_STAT_WAKE_RST    8

// Instruction codes and interrupt mask level.
`define PSM_OPC_HALT         8'h8E
`define PSM_MASK_ALL_ENABLED 2'h2

// Oscillator stabilisation delay in master clock cycles.
`define PSM_STAB_SHORT       256
`define PSM_STAB_LONG        4096

`endif

/* rtl/psm_div_if.sv */
// Connection between the mode controller and its clock divider.
`timescale 1ns/10ps
interface psm_div_if;
   logic       ce;
   logic       slow_en;
   logic [1:0] sel;
   logic       tick;

   modport ctrl
   (
      output ce,
      output slow_en,
      output sel,
      input  tick
   );

   modport div
   (
      input  ce,
      input  slow_en,
      input  sel,
      output tick
   );
endinterface : psm_div_if

/* rtl/psm_pkg.sv */
// Types shared by the power-mode control block.
package psm_pkg;

   typedef enum logic [5:0]
   {
      PSM_RUN   = 6'h01,
      PSM_WAIT  = 6'h02,
      PSM_AHALT = 6'h04,
      PSM_HALT  = 6'h08,
      PSM_STAB  = 6'h10,
      PSM_GUARD = 6'h20
   } psm_mode_t;

   typedef struct packed
   {
      psm_mode_t   mode;
      logic [12:0] dly_cnt;
      logic        wake_rst;
      logic        wake_irq;
      logic [3:0]  ctrl;
      logic [1:0]  opt;
      logic        ack;
      logic [31:0] rdata;
      logic        mask_force;
      logic        irq_service;
      logic        reset_fetch;
      logic        wdg_reset;
   } psm_state_t;

   typedef struct packed
   {
      logic [3:0] cnt;
      logic       tick;
   } psm_div_state_t;

endpackage : psm_pkg

/* tb/psm_cpu_model.sv */
// Behavioural CPU core keeping the interrupt mask and its stack.
`timescale 1ns/10ps
module psm_cpu_model
(
   // Clock and reset.
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset,
   // Controller requests.
   input  wire logic       i_mask_force,
   input  wire logic [1:0] i_mask_bits,
   input  wire logic       i_irq_service,
   input  wire logic [1:0] i_prio,
   // Core view.
   output logic      [1:0] o_cc_mask,
   output int              o_depth
);
   logic [1:0] stack_q[$];

   always @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_cc_mask <= 2'h3;
         o_depth   <= 0;
         stack_q.delete();
      end
      else if (i_irq_service)
      begin
         stack_q.push_back(o_cc_mask);
         o_cc_mask <= i_prio;
         o_depth   <= o_depth + 1;
      end
      else if (i_mask_force)
         o_cc_mask <= i_mask_bits;
   end
endmodule : psm_cpu_model

/* tb/psm_ctrl_assertions.sv */
// Concurrent checks on the ports of the power-mode controller.
`timescale 1ns/10ps
`include "psm_defs.svh"
module psm_ctrl_checker
(
   // Clock, reset and inputs.
   input wire logic       i_clk_sys,
   input wire logic       i_reset,
   input wire logic       i_ce,
   input wire logic       i_instr_valid,
   input wire logic [7:0] i_opcode,
   input wire logic       i_wdg_enabled,
   // Outputs watched.
   input wire logic       o_wdg_reset,
   input wire logic       o_wdg_hold,
   input wire logic       o_osc_on,
   input wire logic       o_rtc_clk_en,
   input wire logic       o_cpu_clk_en,
   input wire logic       o_periph_clk_en,
   input wire logic       o_mask_force,
   input wire logic [1:0] o_mask_bits,
   input wire logic       o_irq_service,
   input wire logic       o_reset_fetch,
   input wire logic       o_slow_wait
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   a_mask_level: assert property
      (o_mask_force |-> o_mask_bits == `PSM_MASK_ALL_ENABLED)
      else $error("mask forced to a wrong level");
   a_halt_entry: assert property
      ($fell(o_osc_on) |->
       $past(i_instr_valid && i_opcode == `PSM_OPC_HALT) && o_mask_force)
      else $error("oscillator stopped without a halt opcode");
   a_halt_dark: assert property
      (!o_osc_on |-> !o_cpu_clk_en && !o_periph_clk_en)
      else $error("clocks run with the oscillator off");
   a_rtc_clock: assert property
      (o_rtc_clk_en == (o_osc_on && i_ce))
      else $error("counter clock does not follow the oscillator");
   a_ahalt_quiet: assert property
      (o_wdg_hold |-> !o_cpu_clk_en && !o_periph_clk_en && !o_wdg_reset)
      else $error("activity in active halt");
   a_slow_wait: assert property
      (o_slow_wait |-> !o_cpu_clk_en)
      else $error("cpu clocked in slow wait");
   a_wdg_cause: assert property
      (o_wdg_reset |->
       $past(i_instr_valid && i_opcode == `PSM_OPC_HALT && i_wdg_enabled)
       ##1 !o_wdg_reset)
      else $error("watchdog reset without a refused halt");
   // Both simulated delays are at least four cycles long.
   a_stab_hold: assert property
      ($rose(o_osc_on) |-> (!o_cpu_clk_en && !o_irq_service
                            && !o_reset_fetch)[*3])
      else $error("cpu resumed inside the stabilisation delay");
endmodule : psm_ctrl_checker

bind psm_ctrl psm_ctrl_checker i_chk
(
   .i_clk_sys, .i_reset, .i_ce, .i_instr_valid, .i_opcode, .i_wdg_enabled,
   .o_wdg_reset, .o_wdg_hold, .o_osc_on, .o_rtc_clk_en, .o_cpu_clk_en,
   .o_periph_clk_en, .o_mask_force, .o_mask_bits, .o_irq_service,
   .o_reset_fetch, .o_slow_wait
);

/* tb/tb.sv */
// Self-checking bench for the power-mode controller.
`timescale 1ns/10ps
`include "psm_defs.svh"
module tb;
   localparam int S = 4;
   localparam int L = 16;
   localparam logic [7:0] WAIT_OP = 8'h8F;
   logic i_clk_sys = 1'b0, i_reset = 1'b1, i_ce = 1'b1;
   logic [3:0] i_avs_address = 4'h0;
   logic i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
   logic i_instr_valid = 1'b0, i_irq_pending = 1'b0, i_ext_irq = 1'b0;
   logic [7:0] i_opcode = 8'h0;
   logic i_rtc_irq = 1'b0, i_halt_wake_irq = 1'b0, i_reset_event = 1'b0;
   logic i_wdg_enabled = 1'b0, o_avs_waitrequest, o_wdg_reset, o_wdg_hold;
   logic o_osc_on, o_rtc_clk_en, o_cpu_clk_en, o_periph_clk_en;
   logic o_mask_force, o_irq_service, o_reset_fetch, o_slow_wait;
   logic [1:0] o_mask_bits, cc, prio = 2'h1;
   logic [3:0] m_ctrl = 4'h0;
   int depth, n_mismatch = 0, check_count = 0, t, b, c;
   int n_svc = 0, n_rf = 0, n_wr = 0, n_mf = 0, n_cpu = 0, n_per = 0;
   int e_svc = 0, e_rf = 0, e_wr = 0, e_mf = 0;
   integer seed = 32'hF3D13F42;

   always #10 i_clk_sys = ~i_clk_sys;

   psm_ctrl #(.WAIT_OPCODE(WAIT_OP), .STAB_SHORT(S), .STAB_LONG(L)) i_dut
   (
      .i_clk_sys, .i_reset, .i_ce, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_instr_valid,
      .i_opcode, .i_irq_pending, .i_ext_irq, .i_rtc_irq, .i_halt_wake_irq,
      .i_reset_event, .i_wdg_enabled, .o_wdg_reset, .o_wdg_hold, .o_osc_on,
      .o_rtc_clk_en, .o_cpu_clk_en, .o_periph_clk_en, .o_mask_force,
      .o_mask_bits, .o_irq_service, .o_reset_fetch, .o_slow_wait
   );
   psm_cpu_model i_cpu
   (
      .i_clk_sys, .i_reset, .i_mask_force(o_mask_force),
      .i_mask_bits(o_mask_bits), .i_irq_service(o_irq_service),
      .i_prio(prio), .o_cc_mask(cc), .o_depth(depth)
   );

   // Pulses are counted from the values standing before each edge.
   always @(posedge i_clk_sys)
   begin
      n_svc <= n_svc + (o_irq_service === 1'b1);
      n_rf  <= n_rf + (o_reset_fetch === 1'b1);
      n_wr  <= n_wr + (o_wdg_reset === 1'b1);
      n_mf  <= n_mf + (o_mask_force === 1'b1);
      n_cpu <= n_cpu + (o_cpu_clk_en === 1'b1);
      n_per <= n_per + (o_periph_clk_en === 1'b1);
   end

   task automatic check(input string nm, input logic [31:0] s, e);
      check_count++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : check

   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_avs_read      <= !w;
      i_avs_write     <= w;
      i_avs_address   <= a;
      i_avs_writedata <= d;
      // Waitrequest and read data are taken at the same rising edge.
      do
      begin
         @(posedge i_clk_sys);
         n++;
      end
      while (o_avs_waitrequest !== 1'b0 && n < 20);
      q = o_avs_readdata;
      n_mismatch += (n >= 20);
      i_avs_read  <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 0);
      check("register", q, e);
   endtask : rd

   // One executed instruction is a single-cycle pulse.
   task automatic exec(input logic [7:0] op);
      @(posedge i_clk_sys);
      i_instr_valid <= 1'b1;
      i_opcode      <= op;
      @(posedge i_clk_sys);
      i_instr_valid <= 1'b0;
   endtask : exec

   task automatic await(input int lo, hi);
      b = n_svc + n_rf + n_wr;
      t = 0;
      while (n_svc + n_rf + n_wr == b && t < 9000)
      begin
         @(negedge i_clk_sys);
         t++;
      end
      check("wake time", t >= lo && t <= hi, 1);
      @(posedge i_clk_sys);
   endtask : await

   task automatic wrap_up;
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      #400000;
      n_mismatch++;
      wrap_up();
   end

   initial
   begin
      repeat (3) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      rd(`PSM_ADDR_STAT, 32'h81);
      rd(`PSM_ADDR_OPT, 32'h0);
      repeat (3)
      begin
         m_ctrl = 4'($random(seed));
         q = $random(seed);
         bus(1'b1, `PSM_ADDR_CTRL, {q[31:4], m_ctrl});
         bus(1'b1, 4'hC, 32'hFFFFFFFF);
         rd(4'hC, 32'h0);
         rd(`PSM_ADDR_CTRL, {28'h0, m_ctrl});
      end
      for (int s = 0; s < 4; s++)
      begin
         bus(1'b1, `PSM_ADDR_CTRL, s * 2 + 1);
         repeat (16) @(negedge i_clk_sys);
         c = n_cpu;
         repeat (64) @(negedge i_clk_sys);
         check("cpu ticks", n_cpu - c, 64 >> (s + 1));
      end
      exec(WAIT_OP);
      e_mf++;
      @(negedge i_clk_sys);
      c = n_cpu;
      b = n_per;
      repeat (64) @(negedge i_clk_sys);
      check("cpu ticks", n_cpu - c, 0);
      check("peripheral ticks", n_per - b, 4);
      check("mask", cc, 2'h2);
      rd(`PSM_ADDR_STAT, 32'hC2);
      prio <= 2'($random(seed));
      i_irq_pending <= 1'b1;
      await(1, 4);
      e_svc++;
      i_irq_pending <= 1'b0;
      check("mask", cc, prio);
      check("stack depth", depth, 1);
      bus(1'b1, `PSM_ADDR_CTRL, 8);
      exec(`PSM_OPC_HALT);
      e_mf++;
      rd(`PSM_ADDR_STAT, 32'h84);
      i_ext_irq <= 1'b1;
      await(1, 4);
      e_svc++;
      i_ext_irq <= 1'b0;
      exec(`PSM_OPC_HALT);
      e_mf++;
      i_reset_event <= 1'b1;
      @(posedge i_clk_sys);
      i_reset_event <= 1'b0;
      await(S - 1, S + 4);
      e_rf++;
      bus(1'b1, `PSM_ADDR_CTRL, 8);
      bus(1'b1, `PSM_ADDR_OPT, 1);
      exec(`PSM_OPC_HALT);
      e_mf++;
      i_rtc_irq <= 1'b1;
      await(1, 4);
      e_svc++;
      i_rtc_irq <= 1'b0;
      bus(1'b1, `PSM_ADDR_CTRL, 0);
      @(negedge i_clk_sys);
      c = n_cpu;
      repeat (4) @(negedge i_clk_sys);
      check("cpu ticks", n_cpu - c, 0);
      repeat (30) @(negedge i_clk_sys);
      rd(`PSM_ADDR_STAT, 32'h81);
      i_ce <= 1'b0;
      @(negedge i_clk_sys);
      c = n_cpu;
      repeat (8) @(negedge i_clk_sys);
      check("frozen cpu ticks", n_cpu - c, 0);
      @(posedge i_clk_sys);
      i_ce <= 1'b1;
      for (int l = 0; l < 2; l++)
      begin
         bus(1'b1, `PSM_ADDR_OPT, l);
         exec(`PSM_OPC_HALT);
         e_mf++;
         rd(`PSM_ADDR_STAT, 32'h08);
         i_halt_wake_irq <= 1'b1;
         await(l ? L : S, (l ? L : S) + 4);
         e_svc++;
         i_halt_wake_irq <= 1'b0;
      end
      bus(1'b1, `PSM_ADDR_OPT, 2);
      i_wdg_enabled <= 1'b1;
      exec(`PSM_OPC_HALT);
      e_wr++;
      rd(`PSM_ADDR_STAT, 32'h81);
      bus(1'b1, `PSM_ADDR_CTRL, 8);
      i_irq_pending <= 1'b1;
      exec(`PSM_OPC_HALT);
      e_mf++;
      await(1, 4);
      e_svc++;
      i_irq_pending <= 1'b0;
      check("service pulses", n_svc, e_svc);
      check("reset fetches", n_rf, e_rf);
      check("watchdog resets", n_wr, e_wr);
      check("mask forces", n_mf, e_mf);
      wrap_up();
   end
endmodule : tb
